/* core/pagpm_pkg.sv */
package pagpm_pkg;
  // Register map, lower 16 address bits
  localparam logic [15:0] PAGPM_ADDR_DIR  = 16'hFFD1;
  localparam logic [15:0] PAGPM_ADDR_DATA = 16'hFFD3;
  // Reset values and fixed read answers
  localparam logic [7:0]  PAGPM_DIR_RST   = 8'h00;
  localparam logic [7:0]  PAGPM_DATA_RST  = 8'h00;
  localparam logic [7:0]  PAGPM_DIR_READ  = 8'hFF;
  localparam logic [7:0]  PAGPM_UNMAPPED  = 8'h00;
  // Pins shared with timer channels
  localparam int          PAGPM_PIN_T2B   = 7;
  localparam int          PAGPM_PIN_T2A   = 6;
  localparam int          PAGPM_PIN_T1B   = 5;
  // Fields of a 3-bit timer side control
  localparam int          PAGPM_CTL_TOP   = 2;
  localparam int          PAGPM_CTL_MID   = 1;
  localparam int          PAGPM_CTL_LOW   = 0;
  // Claim as compare output: top bit 0, low bits not both 0
  function automatic logic pagpm_out_claim(input logic [2:0] ctl);
    pagpm_out_claim = !ctl[PAGPM_CTL_TOP] && (ctl[PAGPM_CTL_MID] || ctl[PAGPM_CTL_LOW]);
  endfunction
endpackage

/* core/pagpm_port.sv */
// Behaviour
// (R1) Unclaimed pin is output when direction bit 1, input when 0.
// (R2) Direction register is write-only; reads return all ones.
// (R3) Reset and hardware standby clear direction to all inputs.
// (R4) Software standby keeps direction, outputs keep driving.
// (R5) Data register read/write, cleared by reset and hardware standby.
// (R6) Port read gives stored data bit where direction bit is 1.
// (R7) Port read gives sampled pin level where direction bit is 0.
// (R8) Pin selection is identical in every processor operating mode.
// (R9) Unclaimed output drives data bit, or pattern output when enabled.
// (R10) Pin 7 drives timer 2 output B when its B control claims it.
// (R11) Pin 7 feeds timer 2 capture B when top bit 1, not pulse mode.
// (R12) Pin 6 drives timer 2 output A in pulse mode or when claimed.
// (R13) Pin 6 feeds timer 2 capture A whenever A top bit is 1.
// (R14) Pin 5 drives timer 1 output B when its B control claims it.
// (R15) Pin 5 feeds timer 1 capture B when top bit 1, not pulse mode.
// (R16) Selection is combinational; pins follow one clock later.
//
// The strobed register port was decided locally.
`timescale 1ns/1ps
`default_nettype none
module pagpm_port
  import pagpm_pkg::*;
#(
  parameter int W = 8
) (
  input  wire logic         i_mclk,
  input  wire logic         i_srst,
  input  wire logic         i_hw_stby,
  input  wire logic         i_sw_stby,
  input  wire logic [15:0]  i_addr,
  input  wire logic [W-1:0] i_wdata,
  input  wire logic         i_wr,
  input  wire logic         i_rd,
  output logic      [W-1:0] o_rdata,
  input  wire logic [W-1:0] i_pin,
  output logic      [W-1:0] o_pin,
  output logic      [W-1:0] o_pin_oe,
  input  wire logic [W-1:0] i_pattern_enable,
  input  wire logic [W-1:0] i_pattern_out,
  input  wire logic         i_timer2_pulse_mode,
  input  wire logic         i_timer1_pulse_mode,
  input  wire logic [2:0]   i_timer2_b_ctl,
  input  wire logic [2:0]   i_timer2_a_ctl,
  input  wire logic [2:0]   i_timer1_b_ctl,
  input  wire logic         i_timer2_io_b_out,
  input  wire logic         i_timer2_io_a_out,
  input  wire logic         i_timer1_io_b_out,
  output logic              o_timer2_io_b_in,
  output logic              o_timer2_io_a_in,
  output logic              o_timer1_io_b_in,
  output logic              o_timer2_cap_b_en,
  output logic              o_timer2_cap_a_en,
  output logic              o_timer1_cap_b_en
);

  logic [W-1:0] dir_reg;
  logic [W-1:0] data_reg;
  logic [W-1:0] pin_next;
  logic [W-1:0] oe_next;
  logic [W-1:0] port_view;
  logic [W-1:0] rdata_next;
  logic         t2b_claim;
  logic         t2a_claim;
  logic         t1b_claim;
  logic         clear_all;

  // Highest pin that no timer channel claims here
  localparam int LOW_TOP = PAGPM_PIN_T1B - 1;

  // Reset and hardware standby both clear; software standby does not
  assign clear_all = i_srst || i_hw_stby; // [R3] [R5] [R4]

  // Direction register, write only
  always_ff @(posedge i_mclk) begin
    if (clear_all) begin
      dir_reg <= PAGPM_DIR_RST; // [R3]
    end else if (i_wr && i_addr == PAGPM_ADDR_DIR) begin
      dir_reg <= i_wdata; // [R4]
    end
  end

  // Data register
  always_ff @(posedge i_mclk) begin
    if (clear_all) begin
      data_reg <= PAGPM_DATA_RST; // [R5]
    end else if (i_wr && i_addr == PAGPM_ADDR_DATA) begin
      data_reg <= i_wdata; // [R5]
    end
  end

  // Port view: data where output, pin level where input
  assign port_view = (dir_reg & data_reg) | (~dir_reg & i_pin); // [R6] [R7]

  // Read decode
  always_comb begin
    rdata_next = PAGPM_UNMAPPED;
    if (i_addr == PAGPM_ADDR_DIR) begin
      rdata_next = PAGPM_DIR_READ; // [R2]
    end else if (i_addr == PAGPM_ADDR_DATA) begin
      rdata_next = port_view; // [R6] [R7]
    end
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      o_rdata <= PAGPM_UNMAPPED;
    end else if (i_rd) begin
      o_rdata <= rdata_next;
    end else begin
      o_rdata <= PAGPM_UNMAPPED;
    end
  end

  // Timer claims; no operating-mode input exists [R8]
  assign t2b_claim = pagpm_out_claim(i_timer2_b_ctl); // [R10]
  assign t2a_claim = i_timer2_pulse_mode || pagpm_out_claim(i_timer2_a_ctl); // [R12]
  assign t1b_claim = pagpm_out_claim(i_timer1_b_ctl); // [R14]

  // Pin function selection
  always_comb begin
    oe_next  = dir_reg; // [R1]
    pin_next = (i_pattern_enable & i_pattern_out) | (~i_pattern_enable & data_reg); // [R9]
    if (t2b_claim) begin
      oe_next[PAGPM_PIN_T2B]  = 1'b1; // [R10]
      pin_next[PAGPM_PIN_T2B] = i_timer2_io_b_out;
    end
    if (t2a_claim) begin
      oe_next[PAGPM_PIN_T2A]  = 1'b1; // [R12]
      pin_next[PAGPM_PIN_T2A] = i_timer2_io_a_out;
    end
    if (t1b_claim) begin
      oe_next[PAGPM_PIN_T1B]  = 1'b1; // [R14]
      pin_next[PAGPM_PIN_T1B] = i_timer1_io_b_out;
    end
  end

  // Registered pin drive, one clock after any selector change
  always_ff @(posedge i_mclk) begin
    if (clear_all) begin
      o_pin    <= PAGPM_DATA_RST;
      o_pin_oe <= PAGPM_DIR_RST;
    end else begin
      o_pin    <= pin_next; // [R16]
      o_pin_oe <= oe_next; // [R16]
    end
  end

  // Capture enables toward the timer
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      o_timer2_cap_b_en <= 1'b0;
      o_timer2_cap_a_en <= 1'b0;
      o_timer1_cap_b_en <= 1'b0;
    end else begin
      o_timer2_cap_b_en <= i_timer2_b_ctl[PAGPM_CTL_TOP] && !i_timer2_pulse_mode; // [R11]
      o_timer2_cap_a_en <= i_timer2_a_ctl[PAGPM_CTL_TOP]; // [R13]
      o_timer1_cap_b_en <= i_timer1_b_ctl[PAGPM_CTL_TOP] && !i_timer1_pulse_mode; // [R15]
    end
  end

  // Capture inputs: pin level, forced low when not selected
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      o_timer2_io_b_in <= 1'b0;
      o_timer2_io_a_in <= 1'b0;
      o_timer1_io_b_in <= 1'b0;
    end else begin
      o_timer2_io_b_in <= i_pin[PAGPM_PIN_T2B] && i_timer2_b_ctl[PAGPM_CTL_TOP]
                          && !i_timer2_pulse_mode; // [R11]
      o_timer2_io_a_in <= i_pin[PAGPM_PIN_T2A] && i_timer2_a_ctl[PAGPM_CTL_TOP]; // [R13]
      o_timer1_io_b_in <= i_pin[PAGPM_PIN_T1B] && i_timer1_b_ctl[PAGPM_CTL_TOP]
                          && !i_timer1_pulse_mode; // [R15]
    end
  end

  // Checks
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_srst);

  a_dir_read_ones: assert property ( // [R2]
    i_rd && i_addr == PAGPM_ADDR_DIR |=> o_rdata == PAGPM_DIR_READ)
    else $error("direction read not all ones");

  a_port_read_mix: assert property ( // [R6]
    i_rd && i_addr == PAGPM_ADDR_DATA && !i_wr
    |=> o_rdata == (($past(dir_reg) & $past(data_reg)) | (~$past(dir_reg) & $past(i_pin))))
    else $error("port read mismatch");

  a_hw_stby_clear: assert property ( // [R3]
    i_hw_stby |=> dir_reg == PAGPM_DIR_RST && data_reg == PAGPM_DATA_RST && o_pin_oe == PAGPM_DIR_RST)
    else $error("hardware standby did not clear");

  a_sw_stby_keep: assert property ( // [R4]
    i_sw_stby && !i_hw_stby && !i_wr |=> $stable(dir_reg) && $stable(data_reg))
    else $error("software standby lost state");

  a_data_write: assert property ( // [R5]
    i_wr && i_addr == PAGPM_ADDR_DATA && !i_hw_stby |=> data_reg == $past(i_wdata))
    else $error("data write not stored");

  a_gpio_drive: assert property ( // [R9]
    !i_hw_stby && !t2b_claim && !t2a_claim && !t1b_claim
    |=> o_pin_oe == $past(dir_reg)
        && (o_pin & o_pin_oe) == ($past(i_pattern_enable) & $past(i_pattern_out) & o_pin_oe
                                  | ~$past(i_pattern_enable) & $past(data_reg) & o_pin_oe))
    else $error("gpio drive wrong");

  a_pin7_timer: assert property ( // [R10]
    !i_hw_stby && t2b_claim |=> o_pin_oe[PAGPM_PIN_T2B] && o_pin[PAGPM_PIN_T2B] == $past(i_timer2_io_b_out))
    else $error("pin 7 timer output missing");

  a_pin6_pulse: assert property ( // [R12]
    !i_hw_stby && i_timer2_pulse_mode |=> o_pin_oe[PAGPM_PIN_T2A]
    && o_pin[PAGPM_PIN_T2A] == $past(i_timer2_io_a_out))
    else $error("pin 6 pulse output missing");

  a_pin5_timer: assert property ( // [R14]
    !i_hw_stby && t1b_claim |=> o_pin_oe[PAGPM_PIN_T1B] && o_pin[PAGPM_PIN_T1B] == $past(i_timer1_io_b_out))
    else $error("pin 5 timer output missing");

  a_cap_enables: assert property ( // [R11] [R13] [R15]
    1'b1 |=> o_timer2_cap_b_en == ($past(i_timer2_b_ctl[PAGPM_CTL_TOP]) && !$past(i_timer2_pulse_mode))
         && o_timer2_cap_a_en == $past(i_timer2_a_ctl[PAGPM_CTL_TOP])
         && o_timer1_cap_b_en == ($past(i_timer1_b_ctl[PAGPM_CTL_TOP]) && !$past(i_timer1_pulse_mode)))
    else $error("capture enable wrong");

  // Register bus: stores, holds, idle answer and split read view
  a_dir_write: assert property ( // [R1]
    i_wr && i_addr == PAGPM_ADDR_DIR && !i_hw_stby |=> dir_reg == $past(i_wdata))
    else $error("direction write not stored");

  a_dir_hold: assert property ( // [R4]
    !(i_wr && i_addr == PAGPM_ADDR_DIR) && !i_hw_stby |=> $stable(dir_reg))
    else $error("direction changed without write");

  a_data_hold: assert property ( // [R5]
    !(i_wr && i_addr == PAGPM_ADDR_DATA) && !i_hw_stby |=> $stable(data_reg))
    else $error("data changed without write");

  a_rdata_idle: assert property ( // [R6]
    !i_rd |=> o_rdata == PAGPM_UNMAPPED)
    else $error("read data not idle");

  a_unmapped_read: assert property ( // [R2]
    i_rd && i_addr != PAGPM_ADDR_DIR && i_addr != PAGPM_ADDR_DATA |=> o_rdata == PAGPM_UNMAPPED)
    else $error("unmapped read not zero");

  a_port_out_bits: assert property ( // [R6]
    i_rd && i_addr == PAGPM_ADDR_DATA
    |=> (o_rdata & $past(dir_reg)) == ($past(data_reg) & $past(dir_reg)))
    else $error("output bits of port read wrong");

  a_port_in_bits: assert property ( // [R7]
    i_rd && i_addr == PAGPM_ADDR_DATA
    |=> (o_rdata & ~$past(dir_reg)) == ($past(i_pin) & ~$past(dir_reg)))
    else $error("input bits of port read wrong");

  // Reset and standby behaviour
  a_srst_clear: assert property ( // [R3]
    disable iff (1'b0) i_srst
    |=> dir_reg == PAGPM_DIR_RST && data_reg == PAGPM_DATA_RST
        && o_pin_oe == PAGPM_DIR_RST && o_rdata == PAGPM_UNMAPPED)
    else $error("reset did not clear");

  a_hw_pin_low: assert property ( // [R3]
    i_hw_stby |=> o_pin == PAGPM_DATA_RST)
    else $error("hardware standby left pin value");

  a_sw_oe_keep: assert property ( // [R4]
    i_sw_stby && !i_hw_stby && !t2b_claim && !t2a_claim && !t1b_claim
    |=> o_pin_oe == $past(dir_reg))
    else $error("software standby dropped drive");

  // Plain port behaviour of each shared pin when unclaimed, and of the low pins up to LOW_TOP
  a_pin7_dir: assert property ( // [R1]
    !i_hw_stby && !t2b_claim |=> o_pin_oe[PAGPM_PIN_T2B] == $past(dir_reg[PAGPM_PIN_T2B]))
    else $error("pin 7 direction wrong");

  a_pin7_value: assert property ( // [R9]
    !i_hw_stby && !t2b_claim && dir_reg[PAGPM_PIN_T2B]
    |=> o_pin[PAGPM_PIN_T2B] == ($past(i_pattern_enable[PAGPM_PIN_T2B])
        ? $past(i_pattern_out[PAGPM_PIN_T2B]) : $past(data_reg[PAGPM_PIN_T2B])))
    else $error("pin 7 value wrong");

  a_pin6_dir: assert property ( // [R1]
    !i_hw_stby && !t2a_claim |=> o_pin_oe[PAGPM_PIN_T2A] == $past(dir_reg[PAGPM_PIN_T2A]))
    else $error("pin 6 direction wrong");

  a_pin6_value: assert property ( // [R9]
    !i_hw_stby && !t2a_claim && dir_reg[PAGPM_PIN_T2A]
    |=> o_pin[PAGPM_PIN_T2A] == ($past(i_pattern_enable[PAGPM_PIN_T2A])
        ? $past(i_pattern_out[PAGPM_PIN_T2A]) : $past(data_reg[PAGPM_PIN_T2A])))
    else $error("pin 6 value wrong");

  a_pin5_dir: assert property ( // [R1]
    !i_hw_stby && !t1b_claim |=> o_pin_oe[PAGPM_PIN_T1B] == $past(dir_reg[PAGPM_PIN_T1B]))
    else $error("pin 5 direction wrong");

  a_pin5_value: assert property ( // [R9]
    !i_hw_stby && !t1b_claim && dir_reg[PAGPM_PIN_T1B]
    |=> o_pin[PAGPM_PIN_T1B] == ($past(i_pattern_enable[PAGPM_PIN_T1B])
        ? $past(i_pattern_out[PAGPM_PIN_T1B]) : $past(data_reg[PAGPM_PIN_T1B])))
    else $error("pin 5 value wrong");

  a_low_oe: assert property ( // [R1]
    !i_hw_stby |=> o_pin_oe[LOW_TOP:0] == $past(dir_reg[LOW_TOP:0]))
    else $error("low pin direction wrong");

  a_low_value: assert property ( // [R9]
    !i_hw_stby |=> (o_pin[LOW_TOP:0] & o_pin_oe[LOW_TOP:0])
        == ((($past(i_pattern_enable[LOW_TOP:0]) & $past(i_pattern_out[LOW_TOP:0]))
        | (~$past(i_pattern_enable[LOW_TOP:0]) & $past(data_reg[LOW_TOP:0]))) & o_pin_oe[LOW_TOP:0]))
    else $error("low pin value wrong");

  // Timer claims override direction one clock later
  a_claim_oe: assert property ( // [R16]
    !i_hw_stby |=> o_pin_oe[PAGPM_PIN_T2B:PAGPM_PIN_T1B]
        == ($past(dir_reg[PAGPM_PIN_T2B:PAGPM_PIN_T1B]) | $past({t2b_claim, t2a_claim, t1b_claim})))
    else $error("claimed pin drive wrong");

  a_pin6_claim: assert property ( // [R12]
    !i_hw_stby && pagpm_out_claim(i_timer2_a_ctl)
    |=> o_pin_oe[PAGPM_PIN_T2A] && o_pin[PAGPM_PIN_T2A] == $past(i_timer2_io_a_out))
    else $error("pin 6 compare output missing");

  a_pin5_free: assert property ( // [R14]
    !i_hw_stby && !t1b_claim && !dir_reg[PAGPM_PIN_T1B] |=> !o_pin_oe[PAGPM_PIN_T1B])
    else $error("pin 5 driven without claim");

  a_pin7_free: assert property ( // [R10]
    !i_hw_stby && !t2b_claim && !dir_reg[PAGPM_PIN_T2B] |=> !o_pin_oe[PAGPM_PIN_T2B])
    else $error("pin 7 driven without claim");

  // Capture inputs carry the pin only when selected
  a_cap_in_b2: assert property ( // [R11]
    1'b1 |=> o_timer2_io_b_in == ($past(i_pin[PAGPM_PIN_T2B]) && $past(i_timer2_b_ctl[PAGPM_CTL_TOP])
        && !$past(i_timer2_pulse_mode)))
    else $error("pin 7 capture input wrong");

  a_cap_in_a2: assert property ( // [R13]
    1'b1 |=> o_timer2_io_a_in == ($past(i_pin[PAGPM_PIN_T2A]) && $past(i_timer2_a_ctl[PAGPM_CTL_TOP])))
    else $error("pin 6 capture input wrong");

  a_cap_in_b1: assert property ( // [R15]
    1'b1 |=> o_timer1_io_b_in == ($past(i_pin[PAGPM_PIN_T1B]) && $past(i_timer1_b_ctl[PAGPM_CTL_TOP])
        && !$past(i_timer1_pulse_mode)))
    else $error("pin 5 capture input wrong");

  c_dir_write: cover property (i_wr && i_addr == PAGPM_ADDR_DIR ##1 i_rd && i_addr == PAGPM_ADDR_DATA);
  c_pattern: cover property (|(dir_reg & i_pattern_enable));
  c_t2b_out: cover property (t2b_claim && dir_reg[PAGPM_PIN_T2B]);
  c_pulse6: cover property (i_timer2_pulse_mode && i_timer2_a_ctl[PAGPM_CTL_TOP]);
  c_sw_hold: cover property (i_sw_stby && |dir_reg);

endmodule
`default_nettype wire

/* dv/pagpm_board.sv */
`timescale 1ns/1ps
`default_nettype none
module pagpm_board (
  input  wire logic [7:0] i_pin_out,
  input  wire logic [7:0] i_pin_oe,
  input  wire logic [7:0] i_ext,
  output logic      [7:0] o_level
);
  // Driven pins follow the port, released pins take the board level
  assign o_level = (i_pin_oe & i_pin_out) | (~i_pin_oe & i_ext);
endmodule
`default_nettype wire

/* dv/tb_port_a_gpio_pin_mux.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_port_a_gpio_pin_mux;
  import pagpm_pkg::*;
  logic        i_mclk = 0, i_srst = 1, hw = 0, sw = 0, wr = 0, rd = 0;
  logic        p2 = 0, p1 = 0, t2b = 0, t2a = 0, t1b = 0;
  logic [2:0]  c2b = 0, c2a = 0, c1b = 0;
  logic [15:0] addr = 0;
  logic [7:0]  wd = 0, pe = 0, po = 0, ext = 8'hB6;
  logic [7:0]  rdat, pin, oe, lvl;
  logic        ib2, ia2, ib1, eb2, ea2, eb1;
  int          errors = 0, checks_done = 0, cyc = 0;
  // Half-period toggle gives 200 MHz
  always #2.5 i_mclk = ~i_mclk;
  pagpm_port dut (.i_mclk(i_mclk), .i_srst(i_srst), .i_hw_stby(hw), .i_sw_stby(sw), .i_addr(addr),
    .i_wdata(wd), .i_wr(wr), .i_rd(rd), .o_rdata(rdat), .i_pin(lvl), .o_pin(pin), .o_pin_oe(oe),
    .i_pattern_enable(pe), .i_pattern_out(po), .i_timer2_pulse_mode(p2), .i_timer1_pulse_mode(p1),
    .i_timer2_b_ctl(c2b), .i_timer2_a_ctl(c2a), .i_timer1_b_ctl(c1b), .i_timer2_io_b_out(t2b),
    .i_timer2_io_a_out(t2a), .i_timer1_io_b_out(t1b), .o_timer2_io_b_in(ib2), .o_timer2_io_a_in(ia2),
    .o_timer1_io_b_in(ib1), .o_timer2_cap_b_en(eb2), .o_timer2_cap_a_en(ea2), .o_timer1_cap_b_en(eb1));
  pagpm_board board (.i_pin_out(pin), .i_pin_oe(oe), .i_ext(ext), .o_level(lvl));
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic conclude();
    $display("checks=%0d mismatches=%0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // One-cycle write strobe
  task automatic wreg(input logic [15:0] a, input logic [7:0] d);
    addr <= a; wd <= d; wr <= 1'b1;
    @(posedge i_mclk); wr <= 1'b0;
  endtask
  // Read strobe, data sampled in the following cycle only
  task automatic rreg(input logic [15:0] a, output logic [7:0] d);
    addr <= a; rd <= 1'b1;
    @(posedge i_mclk); rd <= 1'b0;
    #1 d = rdat;
    @(posedge i_mclk);
  endtask
  // Selector changes reach the pins one edge later; three edges are waited
  task automatic settle();
    repeat (3) @(posedge i_mclk);
    #1;
  endtask
  // Hang guard
  always @(posedge i_mclk) begin
    cyc++;
    if (cyc == 5000) begin
      errors++;
      conclude();
    end
  end
  initial begin
    logic [7:0] v;
    repeat (2) @(posedge i_mclk);
    i_srst <= 1'b0;
    @(posedge i_mclk);
    rreg(PAGPM_ADDR_DIR, v); chk(v, 8'hFF);
    rreg(PAGPM_ADDR_DATA, v); chk(v, ext);
    wreg(PAGPM_ADDR_DIR, 8'hFF); rreg(PAGPM_ADDR_DATA, v); chk(v, 8'h00);
    wreg(PAGPM_ADDR_DIR, 8'hF0); wreg(PAGPM_ADDR_DATA, 8'hA5); settle();
    chk(oe, 8'hF0); chk(pin & 8'hF0, 8'hA0);
    rreg(PAGPM_ADDR_DATA, v); chk(v, 8'hA0 | (ext & 8'h0F));
    rreg(16'hFFD2, v); chk(v, PAGPM_UNMAPPED);
    $display("test 1 done");
    sw <= 1'b1; settle(); chk(oe, 8'hF0);
    rreg(PAGPM_ADDR_DATA, v); chk(v, 8'hA0 | (ext & 8'h0F));
    sw <= 1'b0; hw <= 1'b1; @(posedge i_mclk); hw <= 1'b0; settle();
    chk(oe, 8'h00);
    wreg(PAGPM_ADDR_DIR, 8'hFF); rreg(PAGPM_ADDR_DATA, v); chk(v, 8'h00);
    pe <= 8'hE0; po <= 8'hA0; settle(); chk(pin, 8'hA0);
    $display("test 2 done");
    wreg(PAGPM_ADDR_DIR, 8'h00); c2b <= 3'b001; t2b <= 1'b1; settle();
    chk({oe[7], pin[7]}, 8'h03);
    c2b <= 3'b100; settle(); chk({oe[7], eb2, ib2}, {6'h0, 2'b11});
    p2 <= 1'b1; t2a <= 1'b1; settle(); chk({oe[6], pin[6], eb2}, 8'h06);
    p2 <= 1'b0; c2a <= 3'b100; settle(); chk({oe[6], ea2, ia2}, {6'h0, 1'b1, ext[6]});
    c1b <= 3'b010; t1b <= 1'b1; settle(); chk({oe[5], pin[5]}, 8'h03);
    c1b <= 3'b100; settle(); chk({oe[5], eb1, ib1}, {6'h0, 1'b1, ext[5]});
    p1 <= 1'b1; settle(); chk(eb1, 8'h00);
    $display("test 3 done");
    conclude();
  end
endmodule
`default_nettype wire
